// ### hw/startup_seq_pkg.sv
package startup_seq_pkg;

   // ---------------------------------------------------------------
   // time base
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned TICK_MS = 1;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

   // ---------------------------------------------------------------
   // step times in ms from the wakeup event
   // ---------------------------------------------------------------
   localparam int unsigned WAKE_MS = 0;
   localparam int unsigned REG_ON_MS = 20;
   localparam int unsigned INIT_START_MS = 22;
   localparam int unsigned INIT_DONE_SLOW_MS = 69;
   localparam int unsigned INIT_DONE_FAST_MS = 47;
   localparam int unsigned FULL_SCAN_SLOW_MS = 164;
   localparam int unsigned FULL_SCAN_FAST_MS = 97;
   localparam int unsigned SWITCH_ON_SLOW_MS = 282;
   localparam int unsigned SWITCH_ON_FAST_MS = 283;
   localparam int unsigned SWITCH_EVAL_MS = 250;

   localparam int unsigned MS_W = 10;

   // ---------------------------------------------------------------
   // alarm map bit positions
   // ---------------------------------------------------------------
   localparam int unsigned ALM_INIT_START = 0;
   localparam int unsigned ALM_INIT_DONE = 1;
   localparam int unsigned ALM_SCAN = 2;
   localparam int unsigned ALM_FULL_SCAN = 3;
   localparam int unsigned ALM_W = 4;

endpackage

// ### hw/ms_tick_gen.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// millisecond tick from the system clock
// ---------------------------------------------------------------
module ms_tick_gen #(
   parameter int unsigned CYCLES = startup_seq_pkg::TICK_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic run_i,
   output logic tick_o
);
   logic [$clog2(CYCLES+1)-1:0] cnt_q;

   // restarts with run so the first tick lands one full ms after wakeup
   always_ff @(posedge sys_clk_i) begin
      if (srst_i || !run_i) begin
         cnt_q <= '0;
         tick_o <= 1'b0;
      end else if (cnt_q == $bits(cnt_q)'(CYCLES - 1)) begin
         cnt_q <= '0;
         tick_o <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 1'b1;
         tick_o <= 1'b0;
      end
   end
endmodule

// ### hw/battery_monitor_startup_sequencer.sv
`timescale 1ns/100ps
// Operation
// [R1] after leaving shutdown the steps run in order and normal mode follows.
// [R2] a low wake thermistor pin or a high load detect pin wakes, time zero.
// [R3] if enabled the aux regulator turns on 20 ms after wakeup.
// [R4] the init started flag sets at 22 ms and joins the alarm if mapped.
// [R5] init complete and scan flags set together at 69 ms, or 47 ms fast.
// [R6] the full scan flag sets at 164 ms, or 97 ms fast, mappable to alarm.
// [R7] autonomous switch decisions are made only every 250 ms in normal mode.
// [R8] switches turn on at 282 ms, or 283 ms fast, under autonomous control.
// [R9] the alarm pin drives low while active and is released otherwise.
// [R10] time counts in ms from wakeup and each step fires at its count.
module battery_monitor_startup_sequencer #(
   parameter int unsigned TICK_CYCLES = startup_seq_pkg::TICK_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic wake_thermistor_pin_i,
   input wire logic load_detect_pin_i,
   input wire logic fast_conversion_select_i,
   input wire logic autonomous_switch_control_i,
   input wire logic aux_reg_auto_en_i,
   input wire logic [startup_seq_pkg::ALM_W-1:0] alarm_map_i,
   input wire logic switch_ok_i,
   input wire logic alarm_clear_i,
   output logic aux_regulator_one_o,
   output logic init_started_flag_o,
   output logic init_complete_flag_o,
   output logic conversion_scan_flag_o,
   output logic full_scan_flag_o,
   output logic normal_mode_o,
   output logic switch_en_o,
   output logic alarm_pin_o,
   output logic alarm_pin_oe_o
);
   localparam int unsigned W = startup_seq_pkg::MS_W;

   typedef enum logic [2:0] {
      ST_SHUTDOWN,
      ST_REG_WAIT,
      ST_INIT_WAIT,
      ST_CONV_WAIT,
      ST_FULL_WAIT,
      ST_SWITCH_WAIT,
      ST_NORMAL
   } seq_state_e;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [W-1:0] ms(input int unsigned v);
      return W'(v);
   endfunction

   function automatic logic [W-1:0] pick(input logic fast,
                                         input int unsigned slow_v,
                                         input int unsigned fast_v);
      return fast ? W'(fast_v) : W'(slow_v);
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic ts_meta_q;
   logic ts_sync_q;
   logic ld_meta_q;
   logic ld_sync_q;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         ts_meta_q <= 1'b1;
         ts_sync_q <= 1'b1;
         ld_meta_q <= 1'b0;
         ld_sync_q <= 1'b0;
      end else begin
         ts_meta_q <= wake_thermistor_pin_i;
         ts_sync_q <= ts_meta_q;
         ld_meta_q <= load_detect_pin_i;
         ld_sync_q <= ld_meta_q;
      end
   end

   logic wake_evt;
   assign wake_evt = !ts_sync_q || ld_sync_q; // [R2]

   // ---------------------------------------------------------------
   // time base
   // ---------------------------------------------------------------
   seq_state_e state_q;
   logic running;
   logic tick;
   logic [W-1:0] ms_q;
   logic fast_q;

   assign running = (state_q != ST_SHUTDOWN);

   ms_tick_gen #(
      .CYCLES(TICK_CYCLES)
   ) u_tick (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .run_i(running),
      .tick_o(tick)
   );

   // saturates so a long normal run cannot wrap back onto a step time
   always_ff @(posedge sys_clk_i) begin
      if (srst_i || !running) begin
         ms_q <= '0; // [R2]
      end else if (tick && ms_q != '1) begin
         ms_q <= ms_q + 1'b1; // [R10]
      end
   end

   // mode captured at wakeup so thresholds cannot move mid-sequence
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         fast_q <= 1'b0;
      end else if (state_q == ST_SHUTDOWN && wake_evt) begin
         fast_q <= fast_conversion_select_i;
      end
   end

   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   logic [W-1:0] init_done_ms;
   logic [W-1:0] full_ms;
   logic [W-1:0] sw_ms;

   assign init_done_ms = pick(fast_q, startup_seq_pkg::INIT_DONE_SLOW_MS,
                              startup_seq_pkg::INIT_DONE_FAST_MS);
   assign full_ms = pick(fast_q, startup_seq_pkg::FULL_SCAN_SLOW_MS,
                         startup_seq_pkg::FULL_SCAN_FAST_MS);
   assign sw_ms = pick(fast_q, startup_seq_pkg::SWITCH_ON_SLOW_MS,
                       startup_seq_pkg::SWITCH_ON_FAST_MS);

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         state_q <= ST_SHUTDOWN;
      end else begin
         unique case (state_q)
            ST_SHUTDOWN: begin
               if (wake_evt) begin
                  state_q <= ST_REG_WAIT; // [R2]
               end
            end
            ST_REG_WAIT: begin
               if (ms_q >= ms(startup_seq_pkg::REG_ON_MS)) begin
                  state_q <= ST_INIT_WAIT; // [R1]
               end
            end
            ST_INIT_WAIT: begin
               if (ms_q >= ms(startup_seq_pkg::INIT_START_MS)) begin
                  state_q <= ST_CONV_WAIT; // [R1]
               end
            end
            ST_CONV_WAIT: begin
               if (ms_q >= init_done_ms) begin
                  state_q <= ST_FULL_WAIT; // [R1]
               end
            end
            ST_FULL_WAIT: begin
               if (ms_q >= full_ms) begin
                  state_q <= ST_SWITCH_WAIT; // [R1]
               end
            end
            ST_SWITCH_WAIT: begin
               if (ms_q >= sw_ms) begin
                  state_q <= ST_NORMAL; // [R1]
               end
            end
            ST_NORMAL: begin
               state_q <= ST_NORMAL;
            end
         endcase
      end
   end

   assign normal_mode_o = (state_q == ST_NORMAL); // [R1]

   // ---------------------------------------------------------------
   // step outputs
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         aux_regulator_one_o <= 1'b0;
      end else if (running && aux_reg_auto_en_i &&
                   ms_q >= ms(startup_seq_pkg::REG_ON_MS)) begin
         aux_regulator_one_o <= 1'b1; // [R3]
      end
   end

   // flags are sticky; a fresh set wins over a clear in the same cycle
   logic set_start;
   logic set_done;
   logic set_full;

   assign set_start = (state_q == ST_INIT_WAIT) &&
                      (ms_q >= ms(startup_seq_pkg::INIT_START_MS));
   assign set_done = (state_q == ST_CONV_WAIT) && (ms_q >= init_done_ms);
   assign set_full = (state_q == ST_FULL_WAIT) && (ms_q >= full_ms);

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         init_started_flag_o <= 1'b0;
      end else if (set_start) begin
         init_started_flag_o <= 1'b1; // [R4]
      end else if (alarm_clear_i) begin
         init_started_flag_o <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         init_complete_flag_o <= 1'b0;
         conversion_scan_flag_o <= 1'b0;
      end else if (set_done) begin
         init_complete_flag_o <= 1'b1; // [R5]
         conversion_scan_flag_o <= 1'b1; // [R5]
      end else if (alarm_clear_i) begin
         init_complete_flag_o <= 1'b0;
         conversion_scan_flag_o <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         full_scan_flag_o <= 1'b0;
      end else if (set_full) begin
         full_scan_flag_o <= 1'b1; // [R6]
      end else if (alarm_clear_i) begin
         full_scan_flag_o <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // autonomous switch control
   // ---------------------------------------------------------------
   logic [W-1:0] eval_q;

   // evaluation only on the 250 ms grid; the first evaluation lands 250 ms after entry
   always_ff @(posedge sys_clk_i) begin
      if (srst_i || !normal_mode_o) begin
         eval_q <= '0;
      end else if (tick) begin
         if (eval_q == ms(startup_seq_pkg::SWITCH_EVAL_MS - 1)) begin
            eval_q <= '0; // [R7]
         end else begin
            eval_q <= eval_q + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         switch_en_o <= 1'b0;
      end else if (!autonomous_switch_control_i) begin
         switch_en_o <= 1'b0;
      end else if (state_q == ST_SWITCH_WAIT && ms_q >= sw_ms) begin
         switch_en_o <= switch_ok_i; // [R8]
      end else if (normal_mode_o && tick && eval_q ==
                   ms(startup_seq_pkg::SWITCH_EVAL_MS - 1)) begin
         switch_en_o <= switch_ok_i; // [R7]
      end
   end

   // ---------------------------------------------------------------
   // alarm pin, open drain
   // ---------------------------------------------------------------
   logic [startup_seq_pkg::ALM_W-1:0] alm_src;

   always_comb begin
      alm_src = '0;
      alm_src[startup_seq_pkg::ALM_INIT_START] = init_started_flag_o;
      alm_src[startup_seq_pkg::ALM_INIT_DONE] = init_complete_flag_o;
      alm_src[startup_seq_pkg::ALM_SCAN] = conversion_scan_flag_o;
      alm_src[startup_seq_pkg::ALM_FULL_SCAN] = full_scan_flag_o;
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         alarm_pin_oe_o <= 1'b0;
      end else begin
         alarm_pin_oe_o <= |(alm_src & alarm_map_i); // [R4] [R9]
      end
   end

   assign alarm_pin_o = 1'b0; // [R9]

endmodule

// ### dv/startup_seq_sva.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// startup sequencer port checks
// ---------------------------------------------------------------
module startup_seq_sva (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic autonomous_switch_control_i,
   input wire logic aux_reg_auto_en_i,
   input wire logic [startup_seq_pkg::ALM_W-1:0] alarm_map_i,
   input wire logic aux_regulator_one_o,
   input wire logic init_started_flag_o,
   input wire logic init_complete_flag_o,
   input wire logic conversion_scan_flag_o,
   input wire logic full_scan_flag_o,
   input wire logic normal_mode_o,
   input wire logic switch_en_o,
   input wire logic alarm_pin_o,
   input wire logic alarm_pin_oe_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   logic [3:0] flags;
   assign flags = {full_scan_flag_o, conversion_scan_flag_o,
      init_complete_flag_o, init_started_flag_o};
   AST_PAIR: assert property (
      init_complete_flag_o == conversion_scan_flag_o)
      else $error("init complete and scan flags differ");
   AST_INIT_ORDER: assert property (
      $rose(init_complete_flag_o) |-> init_started_flag_o)
      else $error("init complete before init started");
   AST_FULL_ORDER: assert property (
      $rose(full_scan_flag_o) |-> init_complete_flag_o)
      else $error("full scan before init complete");
   AST_NORMAL_ORDER: assert property (
      $rose(normal_mode_o) |-> full_scan_flag_o ##1 normal_mode_o)
      else $error("normal mode out of order or dropped");
   AST_SW_NORMAL: assert property (
      switch_en_o |-> normal_mode_o)
      else $error("switches on outside normal mode");
   AST_AUTO_OFF: assert property (
      !autonomous_switch_control_i |=> !switch_en_o)
      else $error("switches on without autonomous control");
   AST_REG_FIRST: assert property (
      $rose(init_started_flag_o) && aux_reg_auto_en_i
      |-> aux_regulator_one_o ##1 aux_regulator_one_o)
      else $error("regulator not on before init start");
   AST_ALARM_OE: assert property (
      alarm_pin_oe_o == $past(|(flags & alarm_map_i)))
      else $error("alarm enable does not follow mapped flags");
   AST_ALARM_LOW: assert property (
      alarm_pin_oe_o |-> !alarm_pin_o)
      else $error("alarm pin drives high");
endmodule
bind battery_monitor_startup_sequencer startup_seq_sva i_sva (
   .sys_clk_i, .srst_i, .autonomous_switch_control_i,
   .aux_reg_auto_en_i, .alarm_map_i, .aux_regulator_one_o,
   .init_started_flag_o, .init_complete_flag_o,
   .conversion_scan_flag_o, .full_scan_flag_o, .normal_mode_o,
   .switch_en_o, .alarm_pin_o, .alarm_pin_oe_o);

// ### dv/host_alarm_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// host watching the open-drain alarm line
// ---------------------------------------------------------------
module host_alarm_model (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic alarm_pin_o,
   input wire logic alarm_pin_oe_o,
   output logic alarm_line_o,
   output logic alarm_seen_o
);
   // board pull-up holds the line high once released
   assign alarm_line_o = alarm_pin_oe_o ? alarm_pin_o : 1'b1;
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         alarm_seen_o <= 1'b0;
      end else if (!alarm_line_o) begin
         alarm_seen_o <= 1'b1;
      end
   end
endmodule

// ### dv/testbench.sv
`timescale 1ns/100ps
module testbench;
   localparam int T = 4;
   logic sys_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic therm = 1'b1;
   logic load = 1'b0;
   logic fast = 1'b0;
   logic auto_sw = 1'b1;
   logic reg_en = 1'b1;
   logic sw_ok = 1'b1;
   logic clr = 1'b0;
   logic [startup_seq_pkg::ALM_W-1:0] map = 4'h0;
   logic reg_o, ist, icp, scn, fsc, nrm, swe, apin, aoe, line, seen;
   logic [7:0] obs;
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   int w0 = 0;
   int rise [8];
   // ---------------------------------------------------------------
   // clock, design, host
   // ---------------------------------------------------------------
   always #12.5 sys_clk_i = ~sys_clk_i;
   battery_monitor_startup_sequencer #(.TICK_CYCLES(T))
      i_battery_monitor_startup_sequencer (.sys_clk_i, .srst_i,
      .wake_thermistor_pin_i(therm), .load_detect_pin_i(load),
      .fast_conversion_select_i(fast),
      .autonomous_switch_control_i(auto_sw),
      .aux_reg_auto_en_i(reg_en), .alarm_map_i(map),
      .switch_ok_i(sw_ok), .alarm_clear_i(clr),
      .aux_regulator_one_o(reg_o), .init_started_flag_o(ist),
      .init_complete_flag_o(icp), .conversion_scan_flag_o(scn),
      .full_scan_flag_o(fsc), .normal_mode_o(nrm), .switch_en_o(swe),
      .alarm_pin_o(apin), .alarm_pin_oe_o(aoe));
   host_alarm_model i_host_alarm_model (.sys_clk_i, .srst_i,
      .alarm_pin_o(apin), .alarm_pin_oe_o(aoe), .alarm_line_o(line),
      .alarm_seen_o(seen));
   assign obs = {~line, swe, nrm, fsc, scn, icp, ist, reg_o};
   // first rise of each output, in cycles since reset release
   always @(posedge sys_clk_i) begin
      cyc <= srst_i ? 0 : cyc + 1;
      for (int k = 0; k < 8; k++) begin
         if (srst_i) begin
            rise[k] <= -1;
         end else if (obs[k] === 1'b1 && rise[k] < 0) begin
            rise[k] <= cyc;
         end
      end
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one tick of slack plus sync and register stages
   task automatic chk_ms(input int k, input int ms);
      int d;
      d = rise[k] - w0;
      if (rise[k] >= 0 && d >= ms * T && d <= ms * T + T + 8) d = ms * T;
      check(d, ms * T);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic start(input logic f, input logic ld, input logic re,
         input logic [3:0] m);
      srst_i <= 1'b1;
      fast <= f;
      reg_en <= re;
      map <= m;
      therm <= 1'b1;
      load <= 1'b0;
      auto_sw <= 1'b1;
      sw_ok <= 1'b1;
      repeat (12) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      repeat (20) @(posedge sys_clk_i);
      check({24'h0, obs}, 32'h0);
      if (ld) load <= 1'b1;
      else therm <= 1'b0;
      w0 = cyc;
      for (int i = 0; i < 300 * T; i++) begin
         if (rise[6] >= 0) break;
         @(posedge sys_clk_i);
      end
      if (rise[6] < 0) begin
         err_total++;
         wrap_up();
      end
   endtask
   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      start(1'b0, 1'b0, 1'b1, 4'h2);
      chk_ms(0, 20);
      chk_ms(1, 22);
      chk_ms(2, 69);
      chk_ms(3, 69);
      chk_ms(4, 164);
      chk_ms(5, 282);
      chk_ms(6, 282);
      chk_ms(7, 69);
      sw_ok <= 1'b0;
      repeat (100 * T) @(posedge sys_clk_i);
      check(swe, 1'b1);
      repeat (160 * T) @(posedge sys_clk_i);
      check(swe, 1'b0);
      $display("slow wake test done");
      start(1'b1, 1'b1, 1'b0, 4'h0);
      chk_ms(1, 22);
      chk_ms(2, 47);
      chk_ms(3, 47);
      chk_ms(4, 97);
      chk_ms(6, 283);
      check(rise[0] < 0, 1'b1);
      check(seen, 1'b0);
      therm <= 1'b0;
      auto_sw <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      check(swe, 1'b0);
      check(nrm, 1'b1);
      check({ist, icp, scn, fsc}, 4'hf);
      clr <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      clr <= 1'b0;
      check({ist, icp, scn, fsc}, 4'h0);
      $display("fast wake test done");
      wrap_up();
   end
endmodule
